// ---- tid_core.sv ----
// Instruction decode and execution core with an APB register port.
`timescale 1ns/1ps

module tid_core
    import tid_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // Program memory.
    output logic [8:0]       o_pc,
    input  wire logic [11:0] i_instr,
    // File register space.
    output logic [4:0]       o_file_addr,
    input  wire logic [7:0]  i_file_rdata,
    output logic             o_file_we,
    output logic [7:0]       o_file_wdata,
    // Port B pins and latches.
    input  wire logic [7:0]  i_port_pins,
    output logic [7:0]       o_tristate,
    output logic [7:0]       o_option,
    // Stack.
    output logic             o_stack_push,
    output logic [8:0]       o_push_addr,
    output logic             o_stack_pop,
    input  wire logic [8:0]  i_stack_tos,
    // Watchdog, timer and sleep.
    output logic             o_wdt_clr,
    input  wire logic        i_psc_on_timer,
    output logic             o_psc_clr,
    output logic             o_sleep,
    input  wire logic        i_wake,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr
);

    // ==========================================================
    // State and next-state
    tid_state_t s_q;
    tid_state_t s_d;

    // Execute-stage signals, also watched by the assertions.
    tid_op_t    op;
    logic [7:0] fsrc;
    logic [7:0] res;
    logic [7:0] mask;
    logic [8:0] sum9;
    logic       adv;
    logic       ex;
    logic       dst;
    logic       wr_w;
    logic       wr_f;
    logic       skip;
    logic       jmp;
    logic       setz;
    logic       mapped;
    logic [31:0] rd_mux;

    // ==========================================================
    // Operand selection
    // Decode and operand fetch; port B reads take the pin levels.
    always_comb begin
        op   = tid_decode(s_q.instr);
        fsrc = (s_q.instr[4:0] == SECOND_PORT) ? i_port_pins
                                               : i_file_rdata;
        mask = 8'h01 << s_q.instr[7:5];
        adv  = s_q.run && !(s_q.sleep && !i_wake);
        ex   = adv && (s_q.phase == PH_EXEC) && !s_q.flush;
    end

    // ==========================================================
    // Register read decode
    // Read multiplexer and map check for the APB port.
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (i_paddr)
            OFS_CTRL: rd_mux[RUN_BIT] = s_q.run;
            OFS_STAT: rd_mux[5:0] = {s_q.sleep, s_q.powerdown_flag,
                s_q.timeout_flag, s_q.z, s_q.digit_carry_flag, s_q.c};
            OFS_ACC:  rd_mux[7:0] = s_q.acc;
            OFS_PC:   rd_mux[8:0] = s_q.pc;
            OFS_OPT:  rd_mux[7:0] = s_q.option;
            OFS_TSTATE: rd_mux[7:0] = s_q.tristate;
            default:  mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // Next-state logic
    // Phase sequencing, execution and register bus handling.
    always_comb begin
        s_d       = s_q;
        res       = fsrc;
        sum9      = 9'h000;
        dst       = 1'b0;
        wr_w      = 1'b0;
        wr_f      = 1'b0;
        skip      = 1'b0;
        jmp       = 1'b0;
        setz      = 1'b0;
        s_d.file_we = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.psc_clr = 1'b0;
        s_d.push    = 1'b0;
        s_d.pop     = 1'b0;

        // A wake request ends standby.
        if (s_q.sleep && i_wake) begin
            s_d.sleep = 1'b0;
        end

        // Four clock phases form one instruction cycle.
        if (adv) begin
            s_d.phase = s_q.phase + 2'h1;
            if (s_q.phase == PH_FETCH) begin
                s_d.instr = i_instr;
            end
            if (s_q.phase == PH_EXEC && s_q.flush) begin
                s_d.flush = 1'b0;
            end
        end

        // Execute the latched word in the last phase.
        if (ex) begin
            unique case (op)
                OP_ADD: begin
                    sum9 = {1'b0, fsrc} + {1'b0, s_q.acc};
                    res  = sum9[7:0];
                    s_d.c  = sum9[8];
                    s_d.digit_carry_flag =
                        ({1'b0, fsrc[3:0]} + {1'b0, s_q.acc[3:0]}) > 5'h0F;
                    dst  = 1'b1;
                    setz = 1'b1;
                end
                OP_SUB: begin
                    res    = fsrc - s_q.acc;
                    s_d.c  = fsrc >= s_q.acc;
                    s_d.digit_carry_flag = fsrc[3:0] >= s_q.acc[3:0];
                    dst    = 1'b1;
                    setz   = 1'b1;
                end
                OP_AND: begin
                    res  = s_q.acc & fsrc;
                    dst  = 1'b1;
                    setz = 1'b1;
                end
                OP_IOR: begin
                    res  = s_q.acc | fsrc;
                    dst  = 1'b1;
                    setz = 1'b1;
                end
                OP_XOR: begin
                    res  = s_q.acc ^ fsrc;
                    dst  = 1'b1;
                    setz = 1'b1;
                end
                OP_FILE_MOVE, OP_COM, OP_INC, OP_DEC: begin
                    unique case (op)
                        OP_COM:  res = ~fsrc;
                        OP_INC:  res = fsrc + 8'h01;
                        OP_DEC:  res = fsrc - 8'h01;
                        default: res = fsrc;
                    endcase
                    dst  = 1'b1;
                    setz = 1'b1;
                end
                OP_DECSZ: begin
                    res  = fsrc - 8'h01;
                    skip = (res == 8'h00);
                    dst  = 1'b1;
                end
                OP_INCSZ: begin
                    res  = fsrc + 8'h01;
                    skip = (res == 8'h00);
                    dst  = 1'b1;
                end
                OP_RL: begin
                    res   = {fsrc[6:0], s_q.c};
                    s_d.c = fsrc[7];
                    dst   = 1'b1;
                end
                OP_RR: begin
                    res   = {s_q.c, fsrc[7:1]};
                    s_d.c = fsrc[0];
                    dst   = 1'b1;
                end
                OP_SWAP: begin
                    res = {fsrc[3:0], fsrc[7:4]};
                    dst = 1'b1;
                end
                OP_STORE_ACC: begin
                    res  = s_q.acc;
                    wr_f = 1'b1;
                end
                OP_FILE_CLEAR: begin
                    res  = 8'h00;
                    wr_f = 1'b1;
                    setz = 1'b1;
                end
                OP_ACC_CLEAR: begin
                    res  = 8'h00;
                    wr_w = 1'b1;
                    setz = 1'b1;
                end
                OP_BIT_CLEAR: begin
                    res  = fsrc & ~mask;
                    wr_f = 1'b1;
                end
                OP_BIT_SET: begin
                    res  = fsrc | mask;
                    wr_f = 1'b1;
                end
                OP_TEST_CLEAR: skip = (fsrc & mask) == 8'h00;
                OP_TEST_SET: skip = (fsrc & mask) != 8'h00;
                OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT: begin
                    unique case (op)
                        OP_AND_LIT: res = s_q.acc & s_q.instr[7:0];
                        OP_OR_LIT:  res = s_q.acc | s_q.instr[7:0];
                        default:  res = s_q.acc ^ s_q.instr[7:0];
                    endcase
                    wr_w = 1'b1;
                    setz = 1'b1;
                end
                OP_LOAD_LIT: begin
                    res  = s_q.instr[7:0];
                    wr_w = 1'b1;
                end
                OP_RET_LIT: begin
                    res     = s_q.instr[7:0];
                    wr_w    = 1'b1;
                    s_d.pop = 1'b1;
                    s_d.pc  = i_stack_tos & ~PC_TOP_BIT;
                    jmp     = 1'b1;
                end
                OP_CALL: begin
                    s_d.push      = 1'b1;
                    s_d.push_addr = s_q.pc + 9'h001;
                    s_d.pc        = {1'b0, s_q.instr[7:0]};
                    jmp           = 1'b1;
                end
                OP_JUMP: begin
                    s_d.pc = s_q.instr[8:0];
                    jmp    = 1'b1;
                end
                OP_WDOG_CLEAR: begin
                    s_d.timeout_flag   = 1'b1;
                    s_d.powerdown_flag = 1'b1;
                    s_d.wdt_clr = 1'b1;
                end
                OP_SLEEP: begin
                    s_d.timeout_flag   = 1'b1;
                    s_d.powerdown_flag = 1'b0;
                    s_d.wdt_clr = 1'b1;
                    s_d.sleep   = 1'b1;
                end
                OP_OPTION: s_d.option = s_q.acc;
                OP_TSTATE: s_d.tristate = s_q.acc;
                default: ; // No-op changes nothing.
            endcase

            // Byte operations pick their destination by bit d.
            if (dst) begin
                wr_f = s_q.instr[5];
                wr_w = !s_q.instr[5];
            end
            if (setz) begin
                s_d.z = (res == 8'h00);
            end
            if (wr_w) begin
                s_d.acc = res;
            end
            if (wr_f) begin
                s_d.file_we    = 1'b1;
                s_d.file_wdata = res;
                if (s_q.instr[4:0] == TIMER_ADDR && i_psc_on_timer) begin
                    s_d.psc_clr = 1'b1;
                end
                if (s_q.instr[4:0] == PCL_ADDR) begin
                    s_d.pc = {1'b0, res};
                    jmp    = 1'b1;
                end
            end

            // Skips step over the next word; changes of flow flush.
            if (!jmp) begin
                s_d.pc = s_q.pc + (skip ? 9'h002 : 9'h001);
            end
            s_d.flush = skip || jmp;
        end

        // APB: read data is captured in the setup phase.
        if (i_psel && !i_penable) begin
            s_d.prdata = rd_mux;
        end
        if (i_psel && i_penable && i_pwrite && i_paddr == OFS_CTRL) begin
            s_d.run = i_pwdata[RUN_BIT];
        end
    end

    // ==========================================================
    // State register
    // Registers the whole state; reset takes constants only.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q                <= '0;
            s_q.timeout_flag   <= 1'b1;
            s_q.powerdown_flag <= 1'b1;
            s_q.option         <= OPT_RST;
            s_q.tristate       <= TSTATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // All outputs but o_pready and o_pslverr come straight from the state register.
    assign o_pc         = s_q.pc;
    assign o_file_addr  = s_q.instr[4:0];
    assign o_file_we    = s_q.file_we;
    assign o_file_wdata = s_q.file_wdata;
    assign o_tristate   = s_q.tristate;
    assign o_option     = s_q.option;
    assign o_stack_push = s_q.push;
    assign o_push_addr  = s_q.push_addr;
    assign o_stack_pop  = s_q.pop;
    assign o_wdt_clr    = s_q.wdt_clr;
    assign o_psc_clr    = s_q.psc_clr;
    assign o_sleep      = s_q.sleep;
    assign o_prdata     = s_q.prdata;
    assign o_pready     = 1'b1;
    assign o_pslverr    = i_psel && i_penable && !mapped;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_exec_add_w;
        ex && op == OP_ADD && !s_q.instr[5];
    endsequence

    sequence s_flush_cycle;
        adv && s_q.phase == PH_EXEC && s_q.flush;
    endsequence

    a_add_result: assert property (
        s_exec_add_w |=> s_q.acc == 8'($past(s_q.acc) + $past(fsrc))
    ) else $error("add result wrong");

    a_dest_file: assert property (
        ex && dst && s_q.instr[5] |=> o_file_we
            && o_file_wdata == $past(res) && $stable(s_q.acc)
    ) else $error("file destination not written");

    a_skip_flush: assert property (
        ex && skip |=> s_q.flush && s_q.pc == $past(s_q.pc) + 9'h002
    ) else $error("skip did not flush");

    a_flush_noop: assert property (
        s_flush_cycle |=> !o_file_we && $stable(s_q.acc)
            && $stable(s_q.pc) && !s_q.flush
    ) else $error("flushed word executed");

    a_phase_step: assert property (
        adv |=> s_q.phase == 2'($past(s_q.phase) + 2'h1)
    ) else $error("phase did not advance");

    a_pc_top_clr: assert property (
        ex && (op == OP_CALL || op == OP_RET_LIT) |=> !s_q.pc[8]
    ) else $error("pc bit eight not cleared");

    a_jump_target: assert property (
        ex && op == OP_JUMP |=> s_q.pc == $past(s_q.instr[8:0])
            && s_q.flush && $stable(s_q.z)
    ) else $error("jump target wrong");

    a_sleep_flags: assert property (
        ex && op == OP_SLEEP
            |=> !s_q.powerdown_flag && s_q.timeout_flag && o_sleep
    ) else $error("sleep flags wrong");

    a_psc_clear: assert property (
        ex && wr_f && s_q.instr[4:0] == TIMER_ADDR && i_psc_on_timer
            |=> o_psc_clr ##1 !o_psc_clr
    ) else $error("prescaler not cleared");

endmodule

// ---- tid_core_test.sv ----
// Self-checking bench that runs a short program on the core.
`timescale 1ns/1ps

module tid_core_test;
    import tid_pkg::*;

    // ==========================================================
    // Signals, file model and expectation queues.
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] instr;
    logic [8:0]  pc;
    logic [4:0]  faddr;
    logic        fwe;
    logic [7:0]  fwdata;
    logic [7:0]  frd;
    logic [7:0]  pins;
    logic [7:0]  r;
    logic [8:0]  sum;
    logic [4:0]  dsum;
    logic [7:0]  fmem [32];
    logic [11:0] prog [15];
    logic [32:0] rq [$];
    logic [14:0] wq [$];
    logic [14:0] we;
    logic        psc;
    int          failures;
    int          comparisons;
    int          seed;
    int          n;

    tid_core u_tid_core (
        .i_ref_clk(clk), .i_nrst(nrst), .o_pc(pc), .i_instr(instr),
        .o_file_addr(faddr), .i_file_rdata(frd), .o_file_we(fwe),
        .o_file_wdata(fwdata), .i_port_pins(pins), .o_tristate(),
        .o_option(), .o_stack_push(), .o_push_addr(), .o_stack_pop(),
        .i_stack_tos(9'h000), .o_wdt_clr(), .i_psc_on_timer(1'b1),
        .o_psc_clr(psc), .o_sleep(), .i_wake(1'b0), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr)
    );

    tid_prog_mem u_tid_prog_mem (.i_pc(pc), .o_instr(instr));

    // File space read is combinational, as the core expects.
    assign frd = fmem[faddr];

    // Clock of 8 ns period.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // Reporting and comparison tasks.
    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            failures++;
            $display("mismatch timeout expected 1 seen 0");
            results();
        end
    endtask

    task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch read expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_wr(input logic [14:0] e, input logic [14:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch file_write expected %h seen %h", e, g);
        end
    endtask

    // One APB transfer; a read notes {slverr, data} as expected.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int k;
        if (!wr) rq.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        guard(k < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // ==========================================================
    // Monitor: completed reads and file writes against the notes.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_rd(rq.pop_front(), {pslverr, prdata});
        end
    end

    // File write pulses are looked at mid-cycle, while they stand.
    always @(negedge clk) begin
        if (fwe === 1'b1) begin
            we = (wq.size() > 0) ? wq.pop_front() : 15'h0000;
            chk_wr(we, {psc, 1'b1, faddr, fwdata});
            fmem[faddr] <= fwdata;
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        seed = 30984;
        failures = 0;
        comparisons = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        r = 8'($random(seed));
        pins = 8'($random(seed));
        for (n = 0; n < 32; n++) fmem[n] = 8'($random(seed));
        fmem[16] = r;
        fmem[17] = 8'h01;
        fmem[18] = 8'hFF;
        prog = '{12'hC5A, 12'h1F0, 12'hE0F, 12'hF0A, 12'h711, 12'h033,
                 12'h3D2, 12'h034, 12'h035, 12'h206, 12'h006, 12'h002,
                 12'h004, 12'h021, 12'hA0E};
        for (n = 0; n < 512; n++) u_tid_prog_mem.mem[n] = 12'h000;
        for (n = 0; n < 15; n++) u_tid_prog_mem.mem[n] = prog[n];
        sum = 9'h05A + {1'b0, r};
        dsum = 5'h0A + {1'b0, r[3:0]};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_OPT, 32'h0, {25'h0, OPT_RST});
        apb(1'b0, OFS_TSTATE, 32'h0, {25'h0, TSTATE_RST});
        apb(1'b0, OFS_STAT, 32'h0, 33'h0_0000_0018);
        apb(1'b1, OFS_ACC, 32'h0000_00FF, 33'h0);
        apb(1'b0, OFS_ACC, 32'h0, 33'h0);
        apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000);
        wq.push_back({2'b01, 5'h10, sum[7:0]});
        wq.push_back({2'b01, 5'h15, 8'h00});
        wq.push_back({2'b11, TIMER_ADDR, pins});
        apb(1'b1, OFS_CTRL, 32'h0000_0001, 33'h0);
        apb(1'b0, OFS_CTRL, 32'h0, 33'h0_0000_0001);
        n = 0;
        while (pc !== 9'h00E && n < 400) begin
            @(posedge clk);
            n++;
        end
        guard(n < 400);
        apb(1'b0, OFS_ACC, 32'h0, {25'h0, pins});
        apb(1'b0, OFS_TSTATE, 32'h0, {25'h0, pins});
        apb(1'b0, OFS_OPT, 32'h0, {25'h0, pins});
        apb(1'b0, OFS_PC, 32'h0, 33'h0_0000_000E);
        apb(1'b0, OFS_STAT, 32'h0,
            {30'h3, pins == 8'h00, dsum[4], sum[8]});
        guard(wq.size() == 0);
        results();
    end
endmodule

// ---- tid_pkg.sv ----
// Constants, types and decode function for the instruction decoder.
//
// What this block does
// - Add accumulator and file, update carry flags.
// - Destination bit picks accumulator or file.
// - AND, OR, XOR with file set zero.
// - Rotate file left through carry only.
// - Rotate file right through carry only.
// - Decrement file, skip on zero, no flags.
// - Increment file, skip on zero, no flags.
// - Clear or set file bit, no flags.
// - Test bit, skip if clear or set.
// - AND literal into accumulator, zero flag.
// - OR, XOR literal set zero; load none.
// - Return loading literal, two cycles.
// - Jump to nine-bit literal, two cycles.
// - Program counter writes clear bit eight, except jump.
// - Watchdog clear updates timeout, powerdown flags.
// - Standby entry updates timeout, powerdown flags.
// - Load option register from accumulator.
// - Tristate load for port B address.
// - Port read-modify uses pin levels.
// - Timer register write clears assigned prescaler.
// - Cycle is four clocks; two on change.
// - Taken skip replaces next word with no-op.
package tid_pkg;

    // ==========================================================
    // Instruction cycle phases and file addresses
    localparam logic [1:0] PH_FETCH    = 2'h0;
    localparam logic [1:0] PH_EXEC     = 2'h3;
    localparam logic [4:0] TIMER_ADDR  = 5'h01;
    localparam logic [4:0] PCL_ADDR    = 5'h02;
    localparam logic [4:0] SECOND_PORT = 5'h06;
    localparam logic [8:0] PC_TOP_BIT  = 9'h100;

    // ==========================================================
    // Register map (byte offsets) and field positions
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STAT    = 8'h04;
    localparam logic [7:0] OFS_ACC     = 8'h08;
    localparam logic [7:0] OFS_PC      = 8'h0C;
    localparam logic [7:0] OFS_OPT     = 8'h10;
    localparam logic [7:0] OFS_TSTATE  = 8'h14;
    localparam int         RUN_BIT     = 0;
    localparam logic [7:0] OPT_RST     = 8'hFF;
    localparam logic [7:0] TSTATE_RST  = 8'hFF;

    // ==========================================================
    // Operation codes after decode
    typedef enum logic [5:0] {
        OP_IDLE, OP_OPTION, OP_SLEEP, OP_WDOG_CLEAR, OP_TSTATE,
        OP_STORE_ACC, OP_ACC_CLEAR, OP_FILE_CLEAR, OP_SUB, OP_DEC,
        OP_IOR, OP_AND, OP_XOR, OP_ADD, OP_FILE_MOVE, OP_COM,
        OP_INC, OP_DECSZ, OP_RR, OP_RL, OP_SWAP, OP_INCSZ,
        OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_CLEAR, OP_TEST_SET, OP_RET_LIT,
        OP_CALL, OP_JUMP, OP_LOAD_LIT, OP_OR_LIT, OP_AND_LIT,
        OP_XOR_LIT
    } tid_op_t;

    // Whole state of the core, registered in one process.
    typedef struct packed {
        logic [1:0]  phase;
        logic [11:0] instr;
        logic [8:0]  pc;
        logic [7:0]  acc;
        logic        c;
        logic        digit_carry_flag;
        logic        z;
        logic        timeout_flag;
        logic        powerdown_flag;
        logic        flush;
        logic        sleep;
        logic        run;
        logic [7:0]  option;
        logic [7:0]  tristate;
        logic        file_we;
        logic [7:0]  file_wdata;
        logic        wdt_clr;
        logic        psc_clr;
        logic        push;
        logic        pop;
        logic [8:0]  push_addr;
        logic [31:0] prdata;
    } tid_state_t;

    // Maps a 12-bit instruction word onto an operation.
    function automatic tid_op_t tid_decode(input logic [11:0] w);
        tid_op_t op;
        op = OP_IDLE;
        casez (w)
            12'b0000_0000_0010: op = OP_OPTION;
            12'b0000_0000_0011: op = OP_SLEEP;
            12'b0000_0000_0100: op = OP_WDOG_CLEAR;
            12'b0000_0000_0110: op = OP_TSTATE;
            12'b0000_001?_????: op = OP_STORE_ACC;
            12'b0000_010?_????: op = OP_ACC_CLEAR;
            12'b0000_011?_????: op = OP_FILE_CLEAR;
            12'b0000_10??_????: op = OP_SUB;
            12'b0000_11??_????: op = OP_DEC;
            12'b0001_00??_????: op = OP_IOR;
            12'b0001_01??_????: op = OP_AND;
            12'b0001_10??_????: op = OP_XOR;
            12'b0001_11??_????: op = OP_ADD;
            12'b0010_00??_????: op = OP_FILE_MOVE;
            12'b0010_01??_????: op = OP_COM;
            12'b0010_10??_????: op = OP_INC;
            12'b0010_11??_????: op = OP_DECSZ;
            12'b0011_00??_????: op = OP_RR;
            12'b0011_01??_????: op = OP_RL;
            12'b0011_10??_????: op = OP_SWAP;
            12'b0011_11??_????: op = OP_INCSZ;
            12'b0100_????_????: op = OP_BIT_CLEAR;
            12'b0101_????_????: op = OP_BIT_SET;
            12'b0110_????_????: op = OP_TEST_CLEAR;
            12'b0111_????_????: op = OP_TEST_SET;
            12'b1000_????_????: op = OP_RET_LIT;
            12'b1001_????_????: op = OP_CALL;
            12'b101?_????_????: op = OP_JUMP;
            12'b1100_????_????: op = OP_LOAD_LIT;
            12'b1101_????_????: op = OP_OR_LIT;
            12'b1110_????_????: op = OP_AND_LIT;
            12'b1111_????_????: op = OP_XOR_LIT;
            default:            op = OP_IDLE;
        endcase
        return op;
    endfunction

endpackage

// ---- tid_prog_mem.sv ----
// Program memory model that feeds instruction words to the core.
`timescale 1ns/1ps

module tid_prog_mem (
    // Fetch address and returned word.
    input  wire logic [8:0]  i_pc,
    output logic [11:0]      o_instr
);
    // ==========================================================
    // Storage, filled by the bench before the core is started.
    logic [11:0] mem [512];

    // Asynchronous read, like a plain program store.
    assign o_instr = mem[i_pc];
endmodule
